// [core/ccia_regs.svh]
`ifndef CCIA_REGS_SVH
`define CCIA_REGS_SVH

// Register offsets (word index on the plain register port)
`define CCIA_ADDR_FIXED_SEL   6'h00
`define CCIA_ADDR_ITEM_BASE   6'h01
`define CCIA_ADDR_SUB_BASE    6'h10
`define CCIA_ADDR_LENGTH      6'h18
`define CCIA_ADDR_STATUS      6'h19
`define CCIA_ADDR_MASK        6'h1A

// Reset values
`define CCIA_SEL_NONE         16'h270F
`define CCIA_SUB_RESET        16'h0000
`define CCIA_MASK_RESET       4'h0

// Fixed-format instance codes and their lengths in bytes
`define CCIA_FMT_BASIC_SPD    16'h0046
`define CCIA_FMT_EXT_SPD      16'h0047
`define CCIA_FMT_SPD_TRQ      16'h0048
`define CCIA_FMT_EXT_SPD_TRQ  16'h0049
`define CCIA_FIXED_LEN_SHORT  3'h4
`define CCIA_FIXED_LEN_LONG   3'h6

// Event bit positions in status and mask
`define CCIA_EV_FRAME_DONE    0
`define CCIA_EV_MISSING_ITEM  1
`define CCIA_EV_BAD_FORMAT    2
`define CCIA_EV_OVERRUN       3

// Item byte widths
`define CCIA_WIDTH_MIN        3'h1
`define CCIA_WIDTH_MAX        3'h4

`endif

// [core/ccia_pkg.sv]
package ccia_pkg;

   // Assembly sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FIXED,
      ST_REQ,
      ST_WAIT,
      ST_DATA,
      ST_END
   } ccia_state_t;

   typedef logic [3:0] ccia_events_t;

endpackage : ccia_pkg

// [core/ccia_assembly.sv]
`timescale 1ns/10ps
`include "ccia_regs.svh"
// Contract
// - Total payload length computed from all selections
// - Each item is one to four bytes
// - Selection 9999 gives zero length, omitted
// - Nonexistent item index yields zero data
// - Payload starts with four/six byte fixed block
// - Items follow in order, low byte first
// - Items 1-10 use paired subindices, rest zero
// - Status fields taken from supervisor object
// - Drive state, speed, torque taken from drive object
module ccia_assembly #(
   parameter int         ITEMS         = 14,
   parameter int         SUB_ITEMS     = 10,
   parameter logic [2:0] MISSING_WIDTH = 3'h2
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [5:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [15:0] regRdata,
   output logic             irq,
   input  wire logic        cycleTrigger,
   input  wire logic        faulted,
   input  wire logic        warning,
   input  wire logic        forward_running_flag,
   input  wire logic        reverse_running_flag,
   input  wire logic        ready,
   input  wire logic        network_command_source_flag,
   input  wire logic [7:0]  driveState,
   input  wire logic        network_reference_source_flag,
   input  wire logic        speed_reached_flag,
   input  wire logic [15:0] measured_speed,
   input  wire logic [15:0] measured_torque,
   output logic             lookupReq,
   output logic      [15:0] lookupIndex,
   output logic      [7:0]  lookupSubindex,
   input  wire logic        lookupAck,
   input  wire logic        lookupExists,
   input  wire logic [2:0]  lookupWidth,
   input  wire logic [31:0] lookupData,
   output logic             outValid,
   output logic      [7:0]  outData,
   output logic             outFirst,
   input  wire logic        outReady,
   output logic             frameDone,
   output logic      [7:0]  payloadLength
);

   ccia_pkg::ccia_state_t state_q;
   logic [15:0]           fixedSel_q;
   logic [15:0]           itemSel_q [ITEMS];
   logic [15:0]           subSel_q [SUB_ITEMS/2];
   logic [3:0]            itemIdx_q;
   logic [2:0]            byteIdx_q;
   logic [2:0]            fixedLen_q;
   logic [2:0]            curWidth_q;
   logic [31:0]           itemData_q;
   logic [47:0]           fixedImg_q;
   logic [7:0]            byteCnt_q;
   logic [7:0]            length_q;
   logic                  outValid_q;
   logic [7:0]            outData_q;
   logic                  outFirst_q;
   logic                  frameDone_q;
   logic [15:0]           lookupIndex_q;
   logic [7:0]            lookupSub_q;
   logic [15:0]           regRdata_q;
   ccia_pkg::ccia_events_t status_q;
   ccia_pkg::ccia_events_t mask_q;
   ccia_pkg::ccia_events_t events;
   logic                  slotFree;
   logic                  emit;
   logic [7:0]            emitByte;
   logic [2:0]            fmtLen;
   logic                  itemHit;
   logic                  subHit;
   logic [3:0]            itemOff;
   logic [2:0]            subOff;

   // Fixed block length for a selection; 9999 and unknown codes are empty
   function automatic logic [2:0] fixedLength(input logic [15:0] sel);
      case (sel)
         `CCIA_FMT_BASIC_SPD,
         `CCIA_FMT_EXT_SPD:     fixedLength = `CCIA_FIXED_LEN_SHORT;
         `CCIA_FMT_SPD_TRQ,
         `CCIA_FMT_EXT_SPD_TRQ: fixedLength = `CCIA_FIXED_LEN_LONG;
         default:               fixedLength = 3'h0;
      endcase
   endfunction : fixedLength

   // Source data type widths outside 1..4 are clamped
   function automatic logic [2:0] clampWidth(input logic [2:0] w);
      if (w < `CCIA_WIDTH_MIN) begin
         clampWidth = `CCIA_WIDTH_MIN;
      end else if (w > `CCIA_WIDTH_MAX) begin
         clampWidth = `CCIA_WIDTH_MAX;
      end else begin
         clampWidth = w;
      end
   endfunction : clampWidth

   // Subindex for item idx (0-based): even items low byte, odd items high byte
   function automatic logic [7:0] subFor(input logic [3:0] idx,
                                         input logic [15:0] pair);
      if (32'(idx) >= SUB_ITEMS) begin
         subFor = 8'h00;
      end else if (idx[0]) begin
         subFor = pair[15:8];
      end else begin
         subFor = pair[7:0];
      end
   endfunction : subFor

   // Output slot may take a byte when empty or being drained now
   assign slotFree = !outValid_q || outReady;
   assign fmtLen   = fixedLength(fixedSel_q);
   assign emit     = slotFree && (state_q == ccia_pkg::ST_FIXED || state_q == ccia_pkg::ST_DATA);

   // Byte to emit: fixed image or current item, low byte first
   always_comb begin
      if (state_q == ccia_pkg::ST_FIXED) begin
         emitByte = fixedImg_q[{byteIdx_q, 3'h0} +: 8];
      end else begin
         emitByte = itemData_q[{byteIdx_q[1:0], 3'h0} +: 8];
      end
   end

   // Sequencer: fixed block, then items 1..14 in order, packed
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q    <= ccia_pkg::ST_IDLE;
         itemIdx_q  <= 4'h0;
         byteIdx_q  <= 3'h0;
         fixedLen_q <= 3'h0;
         curWidth_q <= 3'h0;
         itemData_q <= 32'h0000_0000;
         byteCnt_q  <= 8'h00;
      end else begin
         case (state_q)
            ccia_pkg::ST_IDLE: begin
               if (cycleTrigger) begin
                  fixedLen_q <= fmtLen;
                  itemIdx_q  <= 4'h0;
                  byteIdx_q  <= 3'h0;
                  byteCnt_q  <= 8'h00;
                  state_q    <= (fmtLen != 3'h0) ? ccia_pkg::ST_FIXED : ccia_pkg::ST_REQ;
               end
            end
            ccia_pkg::ST_FIXED: begin
               if (slotFree) begin
                  byteCnt_q <= byteCnt_q + 8'h01;
                  if (byteIdx_q == fixedLen_q - 3'h1) begin
                     byteIdx_q <= 3'h0;
                     state_q   <= ccia_pkg::ST_REQ;
                  end else begin
                     byteIdx_q <= byteIdx_q + 3'h1;
                  end
               end
            end
            ccia_pkg::ST_REQ: begin
               if (32'(itemIdx_q) >= ITEMS) begin
                  state_q <= ccia_pkg::ST_END;
               end else if (itemSel_q[itemIdx_q] == `CCIA_SEL_NONE) begin
                  itemIdx_q <= itemIdx_q + 4'h1;
               end else begin
                  state_q <= ccia_pkg::ST_WAIT;
               end
            end
            ccia_pkg::ST_WAIT: begin
               if (lookupAck) begin
                  curWidth_q <= lookupExists ? clampWidth(lookupWidth) : MISSING_WIDTH;
                  itemData_q <= lookupExists ? lookupData : 32'h0000_0000;
                  byteIdx_q  <= 3'h0;
                  state_q    <= ccia_pkg::ST_DATA;
               end
            end
            ccia_pkg::ST_DATA: begin
               if (slotFree) begin
                  byteCnt_q <= byteCnt_q + 8'h01;
                  if (byteIdx_q == curWidth_q - 3'h1) begin
                     byteIdx_q <= 3'h0;
                     itemIdx_q <= itemIdx_q + 4'h1;
                     state_q   <= ccia_pkg::ST_REQ;
                  end else begin
                     byteIdx_q <= byteIdx_q + 3'h1;
                  end
               end
            end
            ccia_pkg::ST_END: begin
               if (slotFree) begin
                  state_q <= ccia_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= ccia_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Lookup address latched on entry so it stays steady while waiting
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lookupIndex_q <= 16'h0000;
         lookupSub_q   <= 8'h00;
      end else if (state_q == ccia_pkg::ST_REQ && 32'(itemIdx_q) < ITEMS) begin
         lookupIndex_q <= itemSel_q[itemIdx_q];
         lookupSub_q   <= subFor(itemIdx_q, subSel_q[itemIdx_q[3:1] % 3'(SUB_ITEMS/2)]);
      end
   end

   assign lookupReq      = (state_q == ccia_pkg::ST_WAIT);
   assign lookupIndex    = lookupIndex_q;
   assign lookupSubindex = lookupSub_q;

   // Snapshot of drive state at trigger so multi-byte values never tear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fixedImg_q <= 48'h0000_0000_0000;
      end else if (state_q == ccia_pkg::ST_IDLE && cycleTrigger) begin
         case (fixedSel_q)
            `CCIA_FMT_EXT_SPD, `CCIA_FMT_EXT_SPD_TRQ: begin
               fixedImg_q[7:0]  <= {speed_reached_flag, network_reference_source_flag,
                                    network_command_source_flag, ready,
                                    reverse_running_flag, forward_running_flag,
                                    warning, faulted};
               fixedImg_q[15:8] <= driveState;
            end
            default: begin
               fixedImg_q[7:0]  <= {5'h00, forward_running_flag, 1'b0, faulted};
               fixedImg_q[15:8] <= 8'h00;
            end
         endcase
         fixedImg_q[31:16] <= measured_speed;
         fixedImg_q[47:32] <= measured_torque;
      end
   end

   // Output byte holding register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         outValid_q <= 1'b0;
         outData_q  <= 8'h00;
         outFirst_q <= 1'b0;
      end else if (emit) begin
         outValid_q <= 1'b1;
         outData_q  <= emitByte;
         outFirst_q <= (byteCnt_q == 8'h00);
      end else if (outReady) begin
         outValid_q <= 1'b0;
         outFirst_q <= 1'b0; // Flag leaves with its byte, never lingers
      end
   end

   assign outValid = outValid_q;
   assign outData  = outData_q;
   assign outFirst = outFirst_q;

   // Frame completion: length published once the last byte is taken
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         length_q    <= 8'h00;
         frameDone_q <= 1'b0;
      end else begin
         frameDone_q <= (state_q == ccia_pkg::ST_END) && slotFree;
         if (state_q == ccia_pkg::ST_END && slotFree) begin
            length_q <= byteCnt_q;
         end
      end
   end

   assign frameDone     = frameDone_q;
   assign payloadLength = length_q;

   // Register decode
   assign itemOff = 4'(regAddr - `CCIA_ADDR_ITEM_BASE);
   assign subOff  = 3'(regAddr - `CCIA_ADDR_SUB_BASE);
   assign itemHit = regAddr >= `CCIA_ADDR_ITEM_BASE && 32'(itemOff) < ITEMS
                    && regAddr < `CCIA_ADDR_SUB_BASE;
   assign subHit  = regAddr >= `CCIA_ADDR_SUB_BASE && 32'(subOff) < SUB_ITEMS/2
                    && regAddr < `CCIA_ADDR_LENGTH;

   // Selection registers; fixed selection takes effect at the next trigger, item and subindex selections when each item is fetched
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fixedSel_q <= `CCIA_SEL_NONE;
         mask_q     <= `CCIA_MASK_RESET;
         for (int i = 0; i < ITEMS; i++) begin
            itemSel_q[i] <= `CCIA_SEL_NONE;
         end
         for (int i = 0; i < SUB_ITEMS/2; i++) begin
            subSel_q[i] <= `CCIA_SUB_RESET;
         end
      end else if (regWrite) begin
         if (regAddr == `CCIA_ADDR_FIXED_SEL) begin
            fixedSel_q <= regWdata;
         end
         if (regAddr == `CCIA_ADDR_MASK) begin
            mask_q <= regWdata[3:0];
         end
         if (itemHit) begin
            itemSel_q[itemOff] <= regWdata;
         end
         if (subHit) begin
            subSel_q[subOff] <= regWdata;
         end
      end
   end

   // Events of this cycle
   always_comb begin
      events = 4'h0;
      events[`CCIA_EV_FRAME_DONE]   = (state_q == ccia_pkg::ST_END) && slotFree;
      events[`CCIA_EV_MISSING_ITEM] = (state_q == ccia_pkg::ST_WAIT) && lookupAck && !lookupExists;
      events[`CCIA_EV_BAD_FORMAT]   = (state_q == ccia_pkg::ST_IDLE) && cycleTrigger
                                      && fmtLen == 3'h0 && fixedSel_q != `CCIA_SEL_NONE;
      events[`CCIA_EV_OVERRUN]      = (state_q != ccia_pkg::ST_IDLE) && cycleTrigger;
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= 4'h0;
      end else begin
         status_q <= (status_q & ~((regWrite && regAddr == `CCIA_ADDR_STATUS) ?
                                   regWdata[3:0] : 4'h0)) | events;
      end
   end

   assign irq = |(status_q & mask_q);

   // Read data, valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         regRdata_q <= 16'h0000;
      end else if (regRead) begin
         if (regAddr == `CCIA_ADDR_FIXED_SEL) begin
            regRdata_q <= fixedSel_q;
         end else if (itemHit) begin
            regRdata_q <= itemSel_q[itemOff];
         end else if (subHit) begin
            regRdata_q <= subSel_q[subOff];
         end else if (regAddr == `CCIA_ADDR_LENGTH) begin
            regRdata_q <= {8'h00, length_q};
         end else if (regAddr == `CCIA_ADDR_STATUS) begin
            regRdata_q <= {12'h000, status_q};
         end else if (regAddr == `CCIA_ADDR_MASK) begin
            regRdata_q <= {12'h000, mask_q};
         end else begin
            regRdata_q <= 16'h0000;
         end
      end else begin
         regRdata_q <= 16'h0000;
      end
   end

   assign regRdata = regRdata_q;

endmodule : ccia_assembly

// [dv/ccia_assembly_properties.sv]
`timescale 1ns/10ps
module ccia_assembly_chk (
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        lookupReq,
   input wire logic [15:0] lookupIndex,
   input wire logic [7:0]  lookupSubindex,
   input wire logic        lookupAck,
   input wire logic        lookupExists,
   input wire logic        outValid,
   input wire logic [7:0]  outData,
   input wire logic        outFirst,
   input wire logic        outReady,
   input wire logic        frameDone,
   input wire logic [7:0]  payloadLength
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [7:0] sentCnt_q;
   // Bytes taken by the sink since the last frame end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) sentCnt_q <= 8'h00;
      else if (frameDone) sentCnt_q <= 8'h00;
      else if (outValid && outReady) sentCnt_q <= sentCnt_q + 8'h01;
   end
   AST_LEN_MATCH: assert property (frameDone |-> payloadLength == sentCnt_q)
      else $error("length differs from bytes sent");
   AST_DONE_PULSE: assert property (frameDone |=> !frameDone && !outValid)
      else $error("frame end not a single pulse");
   AST_LEN_CEIL: assert property (frameDone |-> payloadLength <= 8'h3E)
      else $error("length above six plus fourteen words");
   AST_FIRST_VALID: assert property (outFirst |-> outValid)
      else $error("first flag without valid byte");
   AST_FIRST_ONCE: assert property (outFirst && outReady |=> !outFirst)
      else $error("first flag on a later byte");
   AST_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outData))
      else $error("byte dropped or changed while stalled");
   AST_REQ_STEADY: assert property (lookupReq && !lookupAck |=> lookupReq
      && $stable(lookupIndex) && $stable(lookupSubindex))
      else $error("lookup request changed before answer");
   AST_ITEM_BYTE: assert property (lookupReq && lookupAck |-> ##2 outValid)
      else $error("item byte late after lookup answer");
   AST_MISSING_ZERO: assert property (lookupReq && lookupAck && !lookupExists && outReady
      ##1 outReady |-> ##1 (outValid && outData == 8'h00))
      else $error("missing item byte not zero");
   cover property (frameDone && payloadLength == 8'h04);
   cover property (lookupAck && !lookupExists);
   cover property (outValid && !outReady ##1 outValid && outReady);
endmodule : ccia_assembly_chk

bind ccia_assembly ccia_assembly_chk ccia_assembly_chk_i (
   .core_clk(core_clk), .resetn(resetn), .lookupReq(lookupReq), .lookupIndex(lookupIndex),
   .lookupSubindex(lookupSubindex), .lookupAck(lookupAck), .lookupExists(lookupExists),
   .outValid(outValid), .outData(outData), .outFirst(outFirst), .outReady(outReady),
   .frameDone(frameDone), .payloadLength(payloadLength));

// [dv/ccia_lookup_model.sv]
`timescale 1ns/10ps
// Stand-in for the drive's parameter store; indices from 100h up do not exist
module ccia_lookup_model (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  ackDelay,
   input  wire logic        lookupReq,
   input  wire logic [15:0] lookupIndex,
   input  wire logic [7:0]  lookupSubindex,
   output logic             lookupAck,
   output logic             lookupExists,
   output logic      [2:0]  lookupWidth,
   output logic      [31:0] lookupData
);
   logic [3:0] waitCnt_q;
   // Answer after ackDelay cycles; answer lines churn between answers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         waitCnt_q    <= 4'h0;
         lookupAck    <= 1'b0;
         lookupExists <= 1'b0;
         lookupWidth  <= 3'h0;
         lookupData   <= 32'h0000_0000;
      end else if (lookupReq && !lookupAck && waitCnt_q >= ackDelay) begin
         waitCnt_q    <= 4'h0;
         lookupAck    <= 1'b1;
         lookupExists <= lookupIndex < 16'h0100;
         lookupWidth  <= lookupIndex[2:0]; // Raw width, 0 and 5..7 included
         lookupData   <= {lookupSubindex, lookupIndex[7:0], ~lookupIndex[7:0], 8'h5A};
      end else begin
         waitCnt_q    <= lookupReq ? waitCnt_q + 4'h1 : 4'h0;
         lookupAck    <= 1'b0;
         lookupExists <= ~lookupExists;
         lookupWidth  <= ~lookupWidth;
         lookupData   <= ~lookupData;
      end
   end
endmodule : ccia_lookup_model

// [dv/tb_ccia_assembly.sv]
`timescale 1ns/10ps
module tb_ccia_assembly;
   logic        core_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic [5:0]  regAddr = 6'h00;
   logic [15:0] regWdata = 16'h0000, speed = 16'h0000, torque = 16'h0000;
   logic [15:0] regRdata, lookupIndex;
   logic        irq, lookupReq, lookupAck, lookupExists, outValid, outFirst, frameDone;
   logic        cycleTrigger = 1'b0, outReady = 1'b1, stall = 1'b0;
   logic [7:0]  flags = 8'h00, driveState = 8'h00, lookupSubindex, outData, payloadLength;
   logic [2:0]  lookupWidth;
   logic [31:0] lookupData;
   logic [3:0]  ackDelay = 4'h0;
   logic [7:0]  rx[$], exp[$];
   int          err_total = 0, checked = 0;

   always #25 core_clk = ~core_clk;

   ccia_assembly ccia_assembly_i (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .irq(irq), .cycleTrigger(cycleTrigger), .faulted(flags[0]), .warning(flags[1]),
      .forward_running_flag(flags[2]), .reverse_running_flag(flags[3]), .ready(flags[4]),
      .network_command_source_flag(flags[5]), .driveState(driveState),
      .network_reference_source_flag(flags[6]), .speed_reached_flag(flags[7]),
      .measured_speed(speed), .measured_torque(torque), .lookupReq(lookupReq),
      .lookupIndex(lookupIndex), .lookupSubindex(lookupSubindex), .lookupAck(lookupAck),
      .lookupExists(lookupExists), .lookupWidth(lookupWidth), .lookupData(lookupData),
      .outValid(outValid), .outData(outData), .outFirst(outFirst), .outReady(outReady),
      .frameDone(frameDone), .payloadLength(payloadLength));
   ccia_lookup_model ccia_lookup_model_i (.core_clk(core_clk), .resetn(resetn),
      .ackDelay(ackDelay), .lookupReq(lookupReq), .lookupIndex(lookupIndex),
      .lookupSubindex(lookupSubindex), .lookupAck(lookupAck), .lookupExists(lookupExists),
      .lookupWidth(lookupWidth), .lookupData(lookupData));

   task automatic summarize;
      if (err_total == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize

   task automatic cmp(input logic [15:0] got, input logic [15:0] want);
      checked++;
      if (got !== want) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : cmp

   // Sink; when stalling, ready toggles so both held and taken bytes occur
   always @(posedge core_clk) begin
      if (outValid && outReady) begin
         cmp({15'h0000, outFirst}, {15'h0000, rx.size() == 0});
         rx.push_back(outData);
      end
      outReady <= stall ? ~outReady : 1'b1;
   end

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
      @(posedge core_clk);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [15:0] want);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(negedge core_clk);
      cmp(regRdata, want);
      @(posedge core_clk);
   endtask : rd

   task automatic chkIrq(input logic want);
      @(negedge core_clk);
      cmp({15'h0000, irq}, {15'h0000, want});
      @(posedge core_clk);
   endtask : chkIrq

   // Fixed block as seen by the consumer, status byte first
   task automatic addFixed(input logic [15:0] f);
      exp.push_back(f[0] ? flags : {5'h00, flags[2], 1'b0, flags[0]});
      exp.push_back(f[0] ? driveState : 8'h00);
      exp.push_back(speed[7:0]);
      exp.push_back(speed[15:8]);
      if (f[3]) begin
         exp.push_back(torque[7:0]);
         exp.push_back(torque[15:8]);
      end
   endtask : addFixed

   task automatic addItem(input logic [15:0] idx, input logic [7:0] sub);
      logic [31:0] d;
      int w;
      d = {sub, idx[7:0], ~idx[7:0], 8'h5A};
      w = idx[2:0] == 3'h0 ? 1 : (idx[2:0] > 3'h4 ? 4 : int'(idx[2:0]));
      if (idx >= 16'h0100) w = 2; // Missing item gives two zero bytes
      for (int k = 0; k < w; k++) exp.push_back(idx >= 16'h0100 ? 8'h00 : d[8*k+:8]);
   endtask : addItem

   task automatic frame(input logic dup);
      int n;
      rx.delete();
      cycleTrigger <= 1'b1;
      @(posedge core_clk);
      cycleTrigger <= 1'b0;
      if (dup) begin
         repeat (2) @(posedge core_clk);
         cycleTrigger <= 1'b1;
         @(posedge core_clk);
         cycleTrigger <= 1'b0;
      end
      n = 0;
      while (frameDone !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 500) begin
         cmp(16'h0BAD, 16'h0000);
         summarize();
      end else begin
         cmp({8'h00, payloadLength}, 16'(exp.size()));
         cmp(16'(rx.size()), 16'(exp.size()));
         foreach (exp[k]) cmp({8'h00, rx[k]}, {8'h00, exp[k]});
         @(posedge core_clk);
      end
   endtask : frame

   initial begin
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rd(6'h00, 16'h270F);
      rd(6'h0E, 16'h270F);
      rd(6'h1A, 16'h0000);
      rd(6'h3F, 16'h0000);
      frame(1'b0);
      wr(6'h00, 16'h0050);
      frame(1'b0);
      rd(6'h19, 16'h0005);
      wr(6'h19, 16'h000F);
      // Every fixed format, stalling the sink on every other one
      for (int f = 0; f < 4; f++) begin
         flags <= 8'h96 ^ 8'(f * 59);
         driveState <= 8'(f + 3);
         speed <= 16'h1234 + 16'(f);
         torque <= 16'hBEEF - 16'(f);
         stall <= f[0];
         wr(6'h00, 16'h0046 + 16'(f));
         exp.delete();
         addFixed(16'h0046 + 16'(f));
         frame(1'b0);
      end
      // Items only: missing item 3, skipped item 5, slow then prompt lookups
      wr(6'h00, 16'h270F);
      stall <= 1'b1;
      ackDelay <= 4'h3;
      for (int i = 1; i <= 14; i++) wr(6'(i), 16'h0020 + 16'(i));
      wr(6'h03, 16'h0200);
      wr(6'h05, 16'h270F);
      for (int p = 0; p < 5; p++) wr(6'h10 + 6'(p), {8'(8'h32 + 2 * p), 8'(8'h31 + 2 * p)});
      exp.delete();
      for (int i = 1; i <= 14; i++) begin
         if (i == 3) addItem(16'h0200, 8'h00);
         else if (i != 5) addItem(16'h0020 + 16'(i), i <= 10 ? 8'(8'h30 + i) : 8'h00);
      end
      frame(1'b1);
      stall <= 1'b0;
      ackDelay <= 4'h0;
      frame(1'b0);
      // Events, mask and interrupt line
      rd(6'h19, 16'h000B);
      chkIrq(1'b0);
      wr(6'h1A, 16'h0002);
      chkIrq(1'b1);
      wr(6'h19, 16'h0002);
      chkIrq(1'b0);
      rd(6'h19, 16'h0009);
      wr(6'h18, 16'h00FF);
      rd(6'h18, 16'(exp.size()));
      summarize();
   end
endmodule : tb_ccia_assembly
